// File: core/amrs_pkg.sv
package amrs_pkg;
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_INPUT_SELECT = 8'h00;
	localparam logic [7:0] ADDR_MISC_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_CONV_STATUS = 8'h08;
	localparam logic [7:0] ADDR_RESULT = 8'h0C;
	// Input select fields
	localparam int REFS_HI_BIT = 7;
	localparam int REFS_LO_BIT = 6;
	localparam int LEFT_ADJ_BIT = 5;
	localparam int CHAN_MSB = 4;
	// Misc control fields
	localparam int EXT_REF_EN_BIT = 0;
	localparam int REF_OUT_EN_BIT = 1;
	// Status fields
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_LONG_BIT = 2;
	// Reset values
	localparam logic [7:0] INPUT_SELECT_RST = 8'h00;
	localparam logic [1:0] MISC_RST = 2'h0;
	// Conversion lengths in converter clock cycles
	localparam int NORMAL_CONV_CYCLES = 13;
	localparam int LONG_CONV_CYCLES = 25;
	// Reference source codes
	typedef enum logic [1:0] {
		REF_SUPPLY = 2'b00,
		REF_EXTERNAL = 2'b01,
		REF_INT_1V1 = 2'b10,
		REF_INT_2V56 = 2'b11
	} amrs_ref_e;
	// Gain codes
	typedef enum logic [1:0] {
		GAIN_NONE = 2'b00,
		GAIN_8X = 2'b01,
		GAIN_20X = 2'b10
	} amrs_gain_e;
	// Single-ended internal source codes
	localparam logic [4:0] CH_LAST_PIN = 5'h0A;
	localparam logic [4:0] CH_TEMP = 5'h0B;
	localparam logic [4:0] CH_BANDGAP = 5'h0C;
	localparam logic [4:0] CH_SUPPLY_QTR = 5'h0D;
	localparam logic [4:0] CH_GROUND = 5'h0E;
	localparam logic [4:0] CH_RESERVED = 5'h0F;
endpackage

// File: core/amrs_chan_decode.sv
`timescale 1ns/10ps
module amrs_chan_decode (
	// Channel code
	input wire logic [4:0] code,
	// Multiplexer selects
	output logic [3:0] pos_input,
	output logic [3:0] neg_input,
	output logic diff_mode,
	output logic [1:0] gain,
	output logic sel_temp,
	output logic sel_bandgap,
	output logic sel_supply_qtr,
	output logic sel_ground,
	output logic sel_none
);
	logic [2:0] pair;
	// Decode the channel and gain code
	always_comb begin
		pair = code[3:1];
		pos_input = 4'h0;
		neg_input = 4'h0;
		diff_mode = 1'b0;
		gain = amrs_pkg::GAIN_NONE;
		sel_temp = 1'b0;
		sel_bandgap = 1'b0;
		sel_supply_qtr = 1'b0;
		sel_ground = 1'b0;
		sel_none = 1'b0;
		if (code[4]) begin
			// Differential pairs 0/1,1/2,2/3,4/5,5/6,6/7,8/9,9/10
			diff_mode = 1'b1;
			gain = code[0] ? amrs_pkg::GAIN_20X : amrs_pkg::GAIN_8X;
			case (pair)
				3'h0: pos_input = 4'h0;
				3'h1: pos_input = 4'h1;
				3'h2: pos_input = 4'h2;
				3'h3: pos_input = 4'h4;
				3'h4: pos_input = 4'h5;
				3'h5: pos_input = 4'h6;
				3'h6: pos_input = 4'h8;
				3'h7: pos_input = 4'h9;
				default: pos_input = 4'h0;
			endcase
			neg_input = pos_input + 4'h1;
		end else if (code <= amrs_pkg::CH_LAST_PIN) begin
			pos_input = code[3:0];
		end else begin
			case (code)
				amrs_pkg::CH_TEMP: sel_temp = 1'b1;
				amrs_pkg::CH_BANDGAP: sel_bandgap = 1'b1;
				amrs_pkg::CH_SUPPLY_QTR: sel_supply_qtr = 1'b1;
				amrs_pkg::CH_GROUND: sel_ground = 1'b1;
				default: sel_none = 1'b1;
			endcase
		end
	end
endmodule

// File: core/amrs_top.sv
`timescale 1ns/10ps
module amrs_top (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Conversion sequencer
	input wire logic conv_enable,
	input wire logic conv_busy,
	input wire logic conv_done,
	input wire logic [9:0] conv_result,
	output logic long_conversion,
	// Analog selects
	output logic [3:0] mux_pos_input,
	output logic [3:0] mux_neg_input,
	output logic mux_diff_mode,
	output logic [1:0] mux_gain,
	output logic mux_sel_temp,
	output logic mux_sel_bandgap,
	output logic mux_sel_supply_qtr,
	output logic mux_sel_ground,
	output logic [1:0] ref_source,
	// Reference output pin buffer
	output logic ref_out_drive,
	output logic ref_out_is_2v56,
	// Result data register
	output logic [15:0] result_data
);
	logic [7:0] input_select_ff, nxt_input_select;
	logic [1:0] misc_ff, nxt_misc;
	logic [4:0] chan_applied_ff, nxt_chan_applied;
	logic [1:0] refs_applied_ff, nxt_refs_applied;
	logic long_pending_ff, nxt_long_pending;
	logic done_ff, nxt_done;
	logic [9:0] result_ff, nxt_result;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic ext_ref_en;
	logic ref_out_en;
	logic sel_none_unused;
	logic busy_seen_ff, nxt_busy_seen;
	logic conv_start;
	logic refs_change;

	// Result presentation per alignment
	function automatic logic [15:0] align_result(input logic [9:0] r, input logic left);
		if (left) begin
			align_result = {r, 6'h00};
		end else begin
			align_result = {6'h00, r};
		end
	endfunction

	// Bus decode
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;
	assign addr_ok = (paddr == amrs_pkg::ADDR_INPUT_SELECT) ||
		(paddr == amrs_pkg::ADDR_MISC_CONTROL) || (paddr == amrs_pkg::ADDR_CONV_STATUS) ||
		(paddr == amrs_pkg::ADDR_RESULT);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign ext_ref_en = misc_ff[amrs_pkg::EXT_REF_EN_BIT];
	assign ref_out_en = misc_ff[amrs_pkg::REF_OUT_EN_BIT];
	// First busy cycle marks a conversion start
	assign conv_start = conv_busy && !busy_seen_ff;
	// Software write that changes the reference-select pair
	assign refs_change = wr_en && paddr == amrs_pkg::ADDR_INPUT_SELECT &&
		pwdata[amrs_pkg::REFS_HI_BIT:amrs_pkg::REFS_LO_BIT] !=
		input_select_ff[amrs_pkg::REFS_HI_BIT:amrs_pkg::REFS_LO_BIT];

	// Read data mux
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			case (paddr)
				amrs_pkg::ADDR_INPUT_SELECT: prdata = {24'h000000, input_select_ff};
				amrs_pkg::ADDR_MISC_CONTROL: prdata = {30'h0, misc_ff};
				amrs_pkg::ADDR_CONV_STATUS: prdata = {29'h0, long_pending_ff, conv_busy, done_ff};
				amrs_pkg::ADDR_RESULT: prdata = {16'h0000, result_data};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// Register next-state logic
	always_comb begin
		nxt_input_select = input_select_ff;
		nxt_misc = misc_ff;
		nxt_chan_applied = chan_applied_ff;
		nxt_refs_applied = refs_applied_ff;
		nxt_long_pending = long_pending_ff;
		nxt_done = done_ff;
		nxt_result = result_ff;
		if (wr_en && paddr == amrs_pkg::ADDR_INPUT_SELECT) begin
			nxt_input_select = pwdata[7:0];
		end
		if (wr_en && paddr == amrs_pkg::ADDR_MISC_CONTROL) begin
			nxt_misc = pwdata[1:0];
		end
		// Write-one clears the flag; a new completion wins
		if (wr_en && paddr == amrs_pkg::ADDR_CONV_STATUS && pwdata[amrs_pkg::STAT_DONE_BIT]) begin
			nxt_done = 1'b0;
		end
		if (conv_done) begin
			nxt_result = conv_result;
			nxt_done = 1'b1;
		end
		// Selects apply when idle or at completion
		if (!conv_busy || conv_done) begin
			nxt_chan_applied = input_select_ff[amrs_pkg::CHAN_MSB:0];
			nxt_refs_applied = input_select_ff[amrs_pkg::REFS_HI_BIT:amrs_pkg::REFS_LO_BIT];
		end
		// Long request is consumed by the next start, not by a completion, so a
		// change made mid-conversion still lengthens the conversion after it
		nxt_busy_seen = conv_busy;
		if (conv_start) begin
			nxt_long_pending = 1'b0;
		end
		// A new change wins over consumption
		if (refs_change) begin
			nxt_long_pending = 1'b1;
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_select_ff <= amrs_pkg::INPUT_SELECT_RST;
			misc_ff <= amrs_pkg::MISC_RST;
			chan_applied_ff <= 5'h00;
			refs_applied_ff <= 2'h0;
			long_pending_ff <= 1'b0;
			done_ff <= 1'b0;
			result_ff <= 10'h000;
			busy_seen_ff <= 1'b0;
		end else begin
			input_select_ff <= nxt_input_select;
			misc_ff <= nxt_misc;
			chan_applied_ff <= nxt_chan_applied;
			refs_applied_ff <= nxt_refs_applied;
			long_pending_ff <= nxt_long_pending;
			done_ff <= nxt_done;
			result_ff <= nxt_result;
			busy_seen_ff <= nxt_busy_seen;
		end
	end

	assign long_conversion = long_pending_ff;

	// Immediate alignment from the live register bit
	assign result_data = align_result(result_ff, input_select_ff[amrs_pkg::LEFT_ADJ_BIT]);

	// Reference decode
	always_comb begin
		if (!refs_applied_ff[0]) begin
			ref_source = ext_ref_en ? amrs_pkg::REF_EXTERNAL : amrs_pkg::REF_SUPPLY;
		end else begin
			ref_source = refs_applied_ff[1] ? amrs_pkg::REF_INT_2V56 : amrs_pkg::REF_INT_1V1;
		end
	end

	// Reference output pin drive
	assign ref_out_drive = ref_out_en && conv_enable && refs_applied_ff[0];
	assign ref_out_is_2v56 = refs_applied_ff[1];

	// Channel decode
	amrs_chan_decode u_dec (
		.code(chan_applied_ff),
		.pos_input(mux_pos_input),
		.neg_input(mux_neg_input),
		.diff_mode(mux_diff_mode),
		.gain(mux_gain),
		.sel_temp(mux_sel_temp),
		.sel_bandgap(mux_sel_bandgap),
		.sel_supply_qtr(mux_sel_supply_qtr),
		.sel_ground(mux_sel_ground),
		.sel_none(sel_none_unused)
	);

	// Checks: deferred selects
	a_chan_deferred: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_busy && !conv_done) |=> $stable(chan_applied_ff))
		else $error("channel changed mid conversion");
	a_refs_deferred: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_busy && !conv_done) |=> $stable(refs_applied_ff))
		else $error("reference changed mid conversion");
	a_refs_apply: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done |=> refs_applied_ff == $past(input_select_ff[7:6]))
		else $error("reference not applied at completion");
	a_chan_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(!conv_busy || conv_done) |=> chan_applied_ff == $past(input_select_ff[4:0]))
		else $error("channel not applied");
	a_refs_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(!conv_busy || conv_done) |=> refs_applied_ff == $past(input_select_ff[7:6]))
		else $error("reference not applied");
	// Checks: long conversion request
	a_long_set: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == amrs_pkg::ADDR_INPUT_SELECT && pwdata[7:6] != input_select_ff[7:6])
		|=> long_conversion)
		else $error("long conversion not requested");
	a_long_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(long_pending_ff && !(conv_busy && !busy_seen_ff)) |=> long_conversion)
		else $error("long conversion request lost before start");
	a_long_used: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_busy && !busy_seen_ff && !refs_change) |=> !long_conversion)
		else $error("long conversion request not consumed");
	// Checks: reference pin and reference decode
	a_pin_off: assert property (@(posedge pclk) disable iff (!presetn)
		(!conv_enable || !ref_out_en) |-> !ref_out_drive)
		else $error("reference pin driven while off");
	a_pin_on: assert property (@(posedge pclk) disable iff (!presetn)
		(ref_out_en && conv_enable && refs_applied_ff[0]) |-> ref_out_drive)
		else $error("reference pin not driven");
	a_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
		ref_out_drive |-> ref_out_is_2v56 == refs_applied_ff[1])
		else $error("reference pin level wrong");
	a_pin_mode: assert property (@(posedge pclk) disable iff (!presetn)
		!refs_applied_ff[0] |-> !ref_out_drive)
		else $error("reference pin driven without internal reference");
	a_ref_supply: assert property (@(posedge pclk) disable iff (!presetn)
		(!refs_applied_ff[0] && !ext_ref_en) |-> ref_source == amrs_pkg::REF_SUPPLY)
		else $error("supply reference not chosen");
	a_ref_ext: assert property (@(posedge pclk) disable iff (!presetn)
		(!refs_applied_ff[0] && ext_ref_en) |-> ref_source == amrs_pkg::REF_EXTERNAL)
		else $error("external reference not chosen");
	a_ref_1v1: assert property (@(posedge pclk) disable iff (!presetn)
		(refs_applied_ff == 2'b01 && !ext_ref_en) |-> ref_source == amrs_pkg::REF_INT_1V1)
		else $error("internal 1.1V reference not chosen");
	a_ref_2v56: assert property (@(posedge pclk) disable iff (!presetn)
		(refs_applied_ff == 2'b11 && !ext_ref_en) |-> ref_source == amrs_pkg::REF_INT_2V56)
		else $error("internal 2.56V reference not chosen");
	// Checks: result presentation
	a_left_align: assert property (@(posedge pclk) disable iff (!presetn)
		input_select_ff[5] |-> result_data[15:6] == result_ff && result_data[5:0] == 6'h00)
		else $error("left alignment wrong");
	a_right_align: assert property (@(posedge pclk) disable iff (!presetn)
		!input_select_ff[5] |-> result_data == {6'h00, result_ff})
		else $error("right alignment wrong");
	// Checks: channel decode
	a_chan_single: assert property (@(posedge pclk) disable iff (!presetn)
		(chan_applied_ff <= amrs_pkg::CH_LAST_PIN) |-> mux_pos_input == chan_applied_ff[3:0])
		else $error("single-ended input wrong");
	a_single_gain: assert property (@(posedge pclk) disable iff (!presetn)
		!chan_applied_ff[4] |-> !mux_diff_mode && mux_gain == amrs_pkg::GAIN_NONE)
		else $error("single-ended mode wrong");
	a_chan_temp: assert property (@(posedge pclk) disable iff (!presetn)
		(chan_applied_ff == amrs_pkg::CH_TEMP) |-> mux_sel_temp && !mux_sel_bandgap)
		else $error("temperature sensor not selected");
	a_chan_bandgap: assert property (@(posedge pclk) disable iff (!presetn)
		(chan_applied_ff == amrs_pkg::CH_BANDGAP) |-> mux_sel_bandgap && !mux_sel_supply_qtr)
		else $error("bandgap not selected");
	a_chan_supply: assert property (@(posedge pclk) disable iff (!presetn)
		(chan_applied_ff == amrs_pkg::CH_SUPPLY_QTR) |-> mux_sel_supply_qtr && !mux_sel_ground)
		else $error("supply quarter not selected");
	a_chan_ground: assert property (@(posedge pclk) disable iff (!presetn)
		(chan_applied_ff == amrs_pkg::CH_GROUND) |-> mux_sel_ground && !mux_sel_temp)
		else $error("ground not selected");
	a_chan_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		(chan_applied_ff == amrs_pkg::CH_RESERVED) |-> !(mux_sel_temp || mux_sel_bandgap ||
		mux_sel_supply_qtr || mux_sel_ground))
		else $error("reserved code selected a source");
	a_diff_gain: assert property (@(posedge pclk) disable iff (!presetn)
		chan_applied_ff[4] |-> mux_gain == (chan_applied_ff[0] ? 2'h2 : 2'h1))
		else $error("differential gain wrong");
	a_diff_pair: assert property (@(posedge pclk) disable iff (!presetn)
		chan_applied_ff[4] |-> mux_diff_mode && mux_neg_input == mux_pos_input + 4'h1)
		else $error("differential pair wrong");
	a_diff_skip: assert property (@(posedge pclk) disable iff (!presetn)
		chan_applied_ff[4] |-> mux_pos_input != 4'h3 && mux_pos_input != 4'h7 && mux_pos_input < 4'hA)
		else $error("differential positive input out of set");
	// Checks: registers and completion flag
	a_reg_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == amrs_pkg::ADDR_INPUT_SELECT) |=> input_select_ff == $past(pwdata[7:0]))
		else $error("select register not written");
	a_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !addr_ok) |=> $stable(input_select_ff) && $stable(misc_ff))
		else $error("unmapped access changed a register");
	a_misc_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == amrs_pkg::ADDR_MISC_CONTROL) |=> misc_ff == $past(pwdata[1:0]))
		else $error("misc control not written");
	a_done_set: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done |=> done_ff && result_ff == $past(conv_result))
		else $error("completion flag or result missing");
	a_done_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(done_ff && !(wr_en && paddr == amrs_pkg::ADDR_CONV_STATUS && pwdata[0])) |=> done_ff)
		else $error("completion flag lost");
	a_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == amrs_pkg::ADDR_CONV_STATUS && pwdata[0] && !conv_done) |=> !done_ff)
		else $error("completion flag not cleared");
	// Scenario covers
	c_deferred_write: cover property (@(posedge pclk) disable iff (!presetn)
		conv_busy && wr_en && paddr == amrs_pkg::ADDR_INPUT_SELECT);
	c_pin_driven: cover property (@(posedge pclk) disable iff (!presetn) ref_out_drive);
	c_done_clear: cover property (@(posedge pclk) disable iff (!presetn) done_ff ##1 !done_ff);
	c_long_start: cover property (@(posedge pclk) disable iff (!presetn)
		conv_start && long_pending_ff);
endmodule

// File: dv/amrs_seq_model.sv
`timescale 1ns/10ps
module amrs_seq_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench commands
	input wire logic go,
	input wire logic [9:0] res,
	input wire logic long_conversion,
	// Sequencer side
	output logic conv_busy,
	output logic conv_done,
	output logic [9:0] conv_result
);
	logic [4:0] cnt;
	// One conversion; result only valid in the done cycle, toggles otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 5'h00;
			conv_busy <= 1'b0;
			conv_done <= 1'b0;
			conv_result <= 10'h000;
		end else begin
			conv_done <= 1'b0;
			conv_result <= ~conv_result;
			if (go && !conv_busy) begin
				conv_busy <= 1'b1;
				cnt <= long_conversion ? 5'(amrs_pkg::LONG_CONV_CYCLES) :
					5'(amrs_pkg::NORMAL_CONV_CYCLES);
			end else if (conv_busy) begin
				cnt <= cnt - 5'h01;
				if (cnt == 5'h01) begin
					conv_busy <= 1'b0;
					conv_done <= 1'b1;
					conv_result <= res;
				end
			end
		end
	end
endmodule

// File: dv/amrs_top_tb_top.sv
`timescale 1ns/10ps
module amrs_top_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic conv_enable, conv_busy, conv_done, long_conversion;
	logic [9:0] conv_result, res;
	logic [3:0] mux_pos_input, mux_neg_input;
	logic mux_diff_mode, mux_sel_temp, mux_sel_bandgap, mux_sel_supply_qtr, mux_sel_ground;
	logic [1:0] mux_gain, ref_source;
	logic ref_out_drive, ref_out_is_2v56;
	logic [15:0] result_data;
	int bad_count, checks, k, p, cyc;
	// Clock at 50 ns period
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	amrs_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .conv_enable, .conv_busy, .conv_done, .conv_result,
		.long_conversion, .mux_pos_input, .mux_neg_input, .mux_diff_mode, .mux_gain,
		.mux_sel_temp, .mux_sel_bandgap, .mux_sel_supply_qtr, .mux_sel_ground,
		.ref_source, .ref_out_drive, .ref_out_is_2v56, .result_data);
	amrs_seq_model model (.pclk, .presetn, .go, .res, .long_conversion, .conv_busy,
		.conv_done, .conv_result);
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; holds the request until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			bad_count++;
			finish_test();
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Write, then let the applied selects settle
	task automatic wrs(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		@(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic start(input logic [9:0] v);
		@(posedge pclk);
		res <= v;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (conv_done !== 1'b1 && n < 40);
		cyc = n;
		if (n >= 40) begin
			bad_count++;
			finish_test();
		end
		@(posedge pclk);
		@(negedge pclk);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, conv_enable, go, res} = '0;
		bad_count = 0;
		checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, amrs_pkg::ADDR_INPUT_SELECT, 32'h0);
		chk(r, 32'h0);
		chk({ref_source, ref_out_drive, result_data}, 32'h0);
		xfer(1'b1, amrs_pkg::ADDR_INPUT_SELECT, 32'h5A);
		xfer(1'b0, amrs_pkg::ADDR_INPUT_SELECT, 32'h0);
		chk(r, 32'h5A);
		xfer(1'b0, 8'h10, 32'h0);
		chk(err, 32'h1);
		$display("Test registers finished");
		// Every channel code while idle
		for (k = 0; k < 32; k++) begin
			wrs(amrs_pkg::ADDR_INPUT_SELECT, k);
			p = (k - 16) >> 1;
			p = p + p / 3;
			if (k < 11) begin
				chk({mux_diff_mode, mux_pos_input}, k);
			end else if (k < 15) begin
				chk({mux_sel_temp, mux_sel_bandgap, mux_sel_supply_qtr, mux_sel_ground},
					32'h8 >> (k - 11));
			end else if (k == 15) begin
				chk({mux_diff_mode, mux_sel_temp, mux_sel_bandgap, mux_sel_supply_qtr,
					mux_sel_ground, mux_pos_input}, 32'h0);
			end else if (k > 15) begin
				chk({mux_diff_mode, mux_gain, mux_pos_input, mux_neg_input},
					{1'b1, (k[0] ? 2'h2 : 2'h1), 4'(p), 4'(p + 1)});
			end
		end
		$display("Test channels finished");
		// Reference decode over select and external enable
		for (k = 0; k < 8; k++) begin
			xfer(1'b1, amrs_pkg::ADDR_MISC_CONTROL, {31'h0, k[0]});
			wrs(amrs_pkg::ADDR_INPUT_SELECT, {24'h0, k[2:1], 6'h0});
			if (!k[1]) begin
				chk(ref_source, k[0] ? 32'h1 : 32'h0);
			end else if (!k[0]) begin
				chk(ref_source, k[2] ? 32'h3 : 32'h2);
			end
		end
		// Software keeps the pin pull-up and digital driver off here
		@(posedge pclk);
		conv_enable <= 1'b1;
		xfer(1'b1, amrs_pkg::ADDR_MISC_CONTROL, 32'h2);
		for (k = 0; k < 4; k++) begin
			wrs(amrs_pkg::ADDR_INPUT_SELECT, {24'h0, k[1:0], 6'h0});
			chk(ref_out_drive, k[0]);
			if (k[0]) chk(ref_out_is_2v56, k[1]);
		end
		@(posedge pclk);
		conv_enable <= 1'b0;
		@(negedge pclk);
		chk(ref_out_drive, 32'h0);
		@(posedge pclk);
		conv_enable <= 1'b1;
		wrs(amrs_pkg::ADDR_MISC_CONTROL, 32'h0);
		chk(ref_out_drive, 32'h0);
		$display("Test reference finished");
		// Conversions with deferred selects
		wrs(amrs_pkg::ADDR_INPUT_SELECT, 32'h0);
		start(10'h2A5);
		wait_done;
		chk(result_data, 32'h02A5);
		xfer(1'b0, amrs_pkg::ADDR_CONV_STATUS, 32'h0);
		chk(r[amrs_pkg::STAT_DONE_BIT], 32'h1);
		xfer(1'b1, amrs_pkg::ADDR_CONV_STATUS, 32'h1);
		xfer(1'b0, amrs_pkg::ADDR_CONV_STATUS, 32'h0);
		chk(r[amrs_pkg::STAT_DONE_BIT], 32'h0);
		start(10'h155);
		wrs(amrs_pkg::ADDR_INPUT_SELECT, 32'hE5);
		chk(result_data, 32'hA940);
		chk(mux_pos_input, 32'h0);
		chk(ref_source, 32'h0);
		chk(long_conversion, 32'h1);
		wait_done;
		chk({ref_source, mux_pos_input}, 32'h35);
		chk(result_data, 32'h5540);
		chk(long_conversion, 32'h1);
		// The conversion after a mid-conversion reference change is the long one
		start(10'h0FF);
		wait_done;
		chk(cyc, amrs_pkg::LONG_CONV_CYCLES + 1);
		chk(long_conversion, 32'h0);
		chk(result_data, 32'h3FC0);
		wrs(amrs_pkg::ADDR_INPUT_SELECT, 32'hC5);
		chk(result_data, 32'h00FF);
		chk(long_conversion, 32'h0);
		$display("Test conversion finished");
		// Reset in mid-run returns every register to zero
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, amrs_pkg::ADDR_INPUT_SELECT, 32'h0);
		chk(r, 32'h0);
		chk({long_conversion, ref_source, result_data}, 32'h0);
		start(10'h001);
		wait_done;
		chk(cyc, amrs_pkg::NORMAL_CONV_CYCLES + 1);
		chk(result_data, 32'h0001);
		$display("Test reset finished");
		finish_test();
	end
endmodule
